// ### tcp_pkg.sv
// Constants and carrier types for the transmit cell processor
package tcp_pkg;
  localparam int CELL_BYTES = 53;
  localparam int HCS_POS = 4;
  localparam int FIFO_CELLS = 4;
  localparam int ADR_W = 11;
  // Register indices; byte address is four times the index
  localparam logic [8:0] IDX_CTRL = 9'h060;
  localparam logic [8:0] IDX_IDLE_HDR = 9'h061;
  localparam logic [8:0] IDX_IDLE_PAY = 9'h062;
  localparam logic [8:0] IDX_IRQ_STAT = 9'h06c;
  localparam logic [8:0] IDX_IRQ_CLR = 9'h06d;
  localparam logic [8:0] IDX_IRQ_EN = 9'h06e;
  // Control/status field positions
  localparam int BIT_IRQ_EN = 7;
  localparam int BIT_MISPLACED = 6;
  localparam int BIT_OVERRUN = 5;
  localparam int BIT_CORRUPT = 4;
  localparam int BIT_GEN_N = 3;
  localparam int BIT_COSET = 2;
  localparam int BIT_SCR_DIS = 1;
  localparam int BIT_FLUSH = 0;
  localparam logic [7:0] CTRL_WR_MASK = 8'h9f;
  // Interrupt status field positions
  localparam int IRQ_OVERRUN = 0;
  localparam int IRQ_MISPLACED = 1;
  localparam int IRQ_BITS = 2;
  // Reset values
  localparam logic [7:0] RST_CTRL = 8'h04;
  localparam logic [7:0] RST_IDLE_HDR = 8'h00;
  localparam logic [7:0] RST_IDLE_PAY = 8'h6a;
  // Header check and scrambler
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] COSET = 8'h55;
  localparam int SCR_LEN = 43;
  // Octet pacing
  localparam int CLK_NS = 50;
  localparam int OCTET_NS = 400;
  localparam int OCTET_CYCLES = (OCTET_NS + CLK_NS - 1) / CLK_NS;

  typedef struct packed {
    logic [7:0] data;
    logic start;
    logic wr;
  } tcp_wr_s;

  typedef struct packed {
    logic [7:0] data;
    logic first;
    logic idle;
  } tcp_octet_s;
endpackage : tcp_pkg

// ### tcp_tx_cell_processor.sv
// Transmit cell processor: cell FIFO, idle cell insertion, header check, scrambler
`timescale 1ns/1ps
`default_nettype none
module tcp_tx_cell_processor
  import tcp_pkg::*;
#(
  parameter int OCTET_DIV = OCTET_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [7:0] tx_cell_bus,
  input wire logic tx_cell_start,
  input wire logic tx_cell_write,
  output tcp_octet_s tx_octet,
  output logic tx_octet_valid,
  output logic interrupt_out_n
);
  localparam logic [5:0] LAST_BYTE = 6'(CELL_BYTES - 1);
  localparam logic [5:0] HCS_BYTE = 6'(HCS_POS);
  localparam logic [2:0] FULL = 3'(FIFO_CELLS);

  tcp_wr_s wr_meta;
  tcp_wr_s wr_sync;
  logic [7:0] ctrl;
  logic [7:0] idle_hdr;
  logic [7:0] idle_pay;
  logic ovr_flag;
  logic tx_cell_start_flag;
  logic [IRQ_BITS-1:0] irq_status;
  logic [IRQ_BITS-1:0] irq_enable;
  logic [7:0] mem [FIFO_CELLS][CELL_BYTES];
  logic [2:0] cell_count;
  logic [1:0] wr_slot;
  logic [5:0] wr_byte;
  logic wr_drop;
  logic [1:0] rd_slot;
  logic [5:0] rd_byte;
  logic cur_idle;
  logic [7:0] hcs_acc;
  logic [SCR_LEN-1:0] scr_hist;
  logic [7:0] div_cnt;
  logic octet_en;

  // Write-side decode
  logic flush;
  logic [5:0] wr_pos;
  logic wr_full_drop;
  logic wr_store;
  logic commit;
  logic ovr_evt;
  logic tx_cell_start_evt;
  // Read-side decode
  logic is_idle;
  logic release_cell;
  logic [7:0] src;
  logic [7:0] idle_byte;
  logic [7:0] raw;
  logic [7:0] crc_next;
  logic [7:0] hcs_out;
  logic [7:0] scr_out;
  logic [SCR_LEN-1:0] next_hist;
  logic [7:0] next_data;
  // Bus decode
  logic bus_req;
  logic bus_acc;
  logic [8:0] bus_idx;
  logic bus_wr;
  logic rd_ctrl;
  logic [7:0] next_rdata;
  logic [IRQ_BITS-1:0] irq_evt;

  function automatic logic [7:0] crc8_step(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    logic fb;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      fb = r[7] ^ d[i];
      r = {r[6:0], 1'b0};
      if (fb) begin
        r = r ^ CRC_POLY;
      end
    end
    return r;
  endfunction : crc8_step

  assign flush = ctrl[BIT_FLUSH];

  // Pins come from another domain: two flops before use
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      wr_meta <= '0;
      wr_sync <= '0;
    end else begin
      wr_meta <= '{data: tx_cell_bus, start: tx_cell_start, wr: tx_cell_write};
      wr_sync <= wr_meta;
    end
  end

  always_comb begin
    wr_pos = wr_sync.start ? 6'h00 : wr_byte;
    wr_full_drop = (wr_pos == 6'h00) && (cell_count == FULL);
    wr_store = wr_sync.wr && !flush && !(wr_pos == 6'h00 ? wr_full_drop : wr_drop);
    commit = wr_store && (wr_pos == LAST_BYTE);
    ovr_evt = wr_sync.wr && !flush && wr_full_drop;
    tx_cell_start_evt = wr_sync.wr && !flush && wr_sync.start && (wr_byte != 6'h00);
  end

  // Write pointer and byte counter
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      wr_slot <= '0;
      wr_byte <= '0;
      wr_drop <= 1'b0;
    end else if (flush) begin
      wr_slot <= '0;
      wr_byte <= '0;
      wr_drop <= 1'b0;
    end else if (wr_sync.wr) begin
      if (wr_pos == 6'h00) begin
        wr_drop <= wr_full_drop;
      end
      if (wr_pos == LAST_BYTE) begin
        wr_byte <= '0;
        wr_drop <= 1'b0;
      end else begin
        wr_byte <= wr_pos + 6'h01;
      end
      if (commit) begin
        wr_slot <= wr_slot + 2'h1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (wr_store) begin
      mem[wr_slot][wr_pos] <= wr_sync.data;
    end
  end

  // Complete cells stored; flush wins over everything
  always_ff @(posedge clk_sys) begin
    if (!rstn || flush) begin
      cell_count <= '0;
    end else begin
      cell_count <= cell_count + {2'b00, commit} - {2'b00, release_cell};
    end
  end

  // Octet pacing enable
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      div_cnt <= '0;
      octet_en <= 1'b0;
    end else if (div_cnt == 8'(OCTET_DIV - 1)) begin
      div_cnt <= '0;
      octet_en <= 1'b1;
    end else begin
      div_cnt <= div_cnt + 8'h01;
      octet_en <= 1'b0;
    end
  end

  always_comb begin
    // Flush counts as empty at once, before the cleared count lands
    is_idle = (rd_byte == 6'h00) ? (cell_count == 3'h0 || flush) : cur_idle;
    src = mem[rd_slot][rd_byte];
    case (rd_byte)
      6'd0: idle_byte = {idle_hdr[7:4], 4'h0};
      6'd1, 6'd2: idle_byte = 8'h00;
      6'd3: idle_byte = {4'h0, idle_hdr[3:1], idle_hdr[0]};
      default: idle_byte = idle_pay;
    endcase
    raw = is_idle ? idle_byte : src;
    crc_next = crc8_step(rd_byte == 6'h00 ? 8'h00 : hcs_acc, raw);
    if (ctrl[BIT_GEN_N] && !is_idle) begin
      hcs_out = src;
    end else begin
      hcs_out = ctrl[BIT_COSET] ? (hcs_acc ^ COSET) : hcs_acc;
    end
    if (ctrl[BIT_CORRUPT]) begin
      hcs_out = ~hcs_out;
    end
    // Self-synchronising x^43+1, MSB first
    next_hist = scr_hist;
    for (int i = 7; i >= 0; i--) begin
      scr_out[i] = raw[i] ^ next_hist[SCR_LEN-1];
      next_hist = {next_hist[SCR_LEN-2:0], scr_out[i]};
    end
    if (rd_byte < HCS_BYTE) begin
      next_data = raw;
    end else if (rd_byte == HCS_BYTE) begin
      next_data = hcs_out;
    end else begin
      next_data = ctrl[BIT_SCR_DIS] ? raw : scr_out;
    end
    release_cell = octet_en && (rd_byte == LAST_BYTE) && !cur_idle && !flush;
  end

  // Strobe lags the pacing enable by one cycle, in step with the octet
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      tx_octet_valid <= 1'b0;
    end else begin
      tx_octet_valid <= octet_en;
    end
  end

  // Read slot rewinds with the write side on a flush
  always_ff @(posedge clk_sys) begin
    if (!rstn || flush) begin
      rd_slot <= '0;
    end else if (release_cell) begin
      rd_slot <= rd_slot + 2'h1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      rd_byte <= '0;
      cur_idle <= 1'b1;
      hcs_acc <= '0;
      scr_hist <= '0;
      tx_octet <= '0;
    end else begin
      if (octet_en) begin
        tx_octet <= '{data: next_data, first: rd_byte == 6'h00, idle: is_idle};
        if (rd_byte == 6'h00) begin
          cur_idle <= is_idle;
        end
        if (rd_byte < HCS_BYTE) begin
          hcs_acc <= crc_next;
        end
        // Scrambler only advances over payload, and only when in use
        if (rd_byte > HCS_BYTE && !ctrl[BIT_SCR_DIS]) begin
          scr_hist <= next_hist;
        end
        rd_byte <= (rd_byte == LAST_BYTE) ? 6'h00 : rd_byte + 6'h01;
      end
    end
  end

  // Wishbone classic slave, one wait state
  always_comb begin
    bus_req = wb_cyc_i && wb_stb_i;
    bus_acc = bus_req && !wb_ack_o;
    bus_idx = wb_adr_i[ADR_W-1:2];
    bus_wr = bus_acc && wb_we_i && wb_sel_i[0];
    rd_ctrl = bus_acc && !wb_we_i && (bus_idx == IDX_CTRL);
    irq_evt = '0;
    irq_evt[IRQ_OVERRUN] = ovr_evt;
    irq_evt[IRQ_MISPLACED] = tx_cell_start_evt;
    case (bus_idx)
      IDX_CTRL: begin
        next_rdata = ctrl & CTRL_WR_MASK;
        next_rdata[BIT_OVERRUN] = ovr_flag;
        next_rdata[BIT_MISPLACED] = tx_cell_start_flag;
      end
      IDX_IDLE_HDR: next_rdata = idle_hdr;
      IDX_IDLE_PAY: next_rdata = idle_pay;
      IDX_IRQ_STAT: next_rdata = {6'h00, irq_status};
      IDX_IRQ_EN: next_rdata = {6'h00, irq_enable};
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= bus_acc;
      if (bus_acc && !wb_we_i) begin
        wb_dat_o <= {24'h000000, next_rdata};
      end
    end
  end

  // Flag bits are read-only, so they are masked off on write
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      ctrl <= RST_CTRL;
    end else if (bus_wr && bus_idx == IDX_CTRL) begin
      ctrl <= wb_dat_i[7:0] & CTRL_WR_MASK;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      idle_hdr <= RST_IDLE_HDR;
    end else if (bus_wr && bus_idx == IDX_IDLE_HDR) begin
      idle_hdr <= wb_dat_i[7:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      idle_pay <= RST_IDLE_PAY;
    end else if (bus_wr && bus_idx == IDX_IDLE_PAY) begin
      idle_pay <= wb_dat_i[7:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      irq_enable <= '0;
    end else if (bus_wr && bus_idx == IDX_IRQ_EN) begin
      irq_enable <= wb_dat_i[IRQ_BITS-1:0];
    end
  end

  // Event flags: a new event wins over a clear in the same cycle
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      ovr_flag <= 1'b0;
    end else begin
      ovr_flag <= ovr_evt || (ovr_flag && !rd_ctrl);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      tx_cell_start_flag <= 1'b0;
    end else begin
      tx_cell_start_flag <= tx_cell_start_evt || (tx_cell_start_flag && !rd_ctrl);
    end
  end

  // Sticky status; a clear only drops the bits that software names
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      irq_status <= '0;
    end else if (bus_wr && bus_idx == IDX_IRQ_CLR) begin
      irq_status <= (irq_status & ~wb_dat_i[IRQ_BITS-1:0]) | irq_evt;
    end else begin
      irq_status <= irq_status | irq_evt;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      interrupt_out_n <= 1'b1;
    end else begin
      interrupt_out_n <= !((ctrl[BIT_IRQ_EN] && (ovr_flag || tx_cell_start_flag))
        || (|(irq_status & irq_enable)));
    end
  end
endmodule : tcp_tx_cell_processor
`default_nettype wire

// ### tcp_tx_cell_processor_assertions.sv
// Port-level assertions for the transmit cell processor
`timescale 1ns/1ps
`default_nettype none
module tcp_tx_cell_processor_assertions
  import tcp_pkg::*;
#(
  parameter int OCTET_DIV = OCTET_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire tcp_octet_s tx_octet,
  input wire logic tx_octet_valid,
  input wire logic interrupt_out_n
);
  logic [5:0] oct_idx;
  logic seen;
  int gap;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // Index of the last octet seen, so checks know where in the cell they are
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      oct_idx <= 6'h00;
      seen <= 1'b0;
      gap <= 0;
    end else if (tx_octet_valid) begin
      oct_idx <= tx_octet.first ? 6'h00 : oct_idx + 6'h01;
      seen <= 1'b1;
      gap <= 0;
    end else begin
      gap <= gap + 1;
    end
  end
  ack_once_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  ack_next_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
  dat_high_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000) else $error("read bits high");
  rst_quiet_a: assert property (disable iff (1'b0) !rstn |=> interrupt_out_n && !wb_ack_o && !tx_octet_valid)
    else $error("busy in reset");
  pace_a: assert property (tx_octet_valid && seen |-> gap == OCTET_DIV - 1) else $error("octet pace");
  hold_a: assert property (!tx_octet_valid |-> $stable(tx_octet)) else $error("octet moved");
  cell_len_a: assert property (tx_octet_valid && seen |-> tx_octet.first == (oct_idx == 6'd52))
    else $error("cell length");
  idle_vpi_a: assert property (tx_octet_valid && tx_octet.idle && seen && !tx_octet.first && oct_idx < 6'd2
    |-> tx_octet.data == 8'h00) else $error("idle path id");
  cover property (tx_octet_valid && tx_octet.first && !tx_octet.idle);
  cover property (!interrupt_out_n);
  cover property (wb_ack_o && !wb_we_i);
endmodule : tcp_tx_cell_processor_assertions
bind tcp_tx_cell_processor tcp_tx_cell_processor_assertions #(.OCTET_DIV(OCTET_DIV)) u_tcp_chk (.clk_sys, .rstn,
  .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_dat_o, .wb_ack_o, .tx_octet, .tx_octet_valid, .interrupt_out_n);
`default_nettype wire

// ### tcp_cell_writer.sv
// Cell writer model standing in for the layer device
`timescale 1ns/1ps
`default_nettype none
module tcp_cell_writer (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic go,
  input wire logic bad,
  input wire logic [7:0] fill,
  output logic busy,
  output logic [7:0] tx_cell_bus,
  output logic tx_cell_start,
  output logic tx_cell_write
);
  logic [5:0] i;
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      busy <= 1'b0;
      tx_cell_write <= 1'b0;
      tx_cell_start <= 1'b0;
      tx_cell_bus <= 8'h00;
    end else if (busy) begin
      tx_cell_write <= 1'b1;
      tx_cell_start <= i == 6'd0 || (bad && i == 6'd10);
      tx_cell_bus <= fill + {2'b00, i};
      i <= i + 6'd1;
      busy <= i != 6'd52;
    end else begin
      // Released bus toggles so stale data never looks valid
      tx_cell_write <= 1'b0;
      tx_cell_start <= 1'b0;
      tx_cell_bus <= ~tx_cell_bus;
      i <= 6'd0;
      busy <= go;
    end
  end
endmodule : tcp_cell_writer
`default_nettype wire

// ### tcp_tx_cell_processor_tb_top.sv
// Self-checking bench for the transmit cell processor
`timescale 1ns/1ps
`default_nettype none
module tcp_tx_cell_processor_tb_top
  import tcp_pkg::*;
;
  logic clk_sys = 1'b0;
  logic rstn, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, tx_cell_start, tx_cell_write, tx_octet_valid, interrupt_out_n;
  logic [ADR_W-1:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [7:0] tx_cell_bus, q, fill;
  logic [7:0] c [53];
  logic go, bad, busy, cid;
  tcp_octet_s tx_octet;
  int miscompares = 0;
  int tests_run = 0;
  always #25 clk_sys = ~clk_sys;
  tcp_tx_cell_processor #(.OCTET_DIV(8)) u_tcp_tx_cell_processor (.clk_sys, .rstn, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .tx_cell_bus, .tx_cell_start, .tx_cell_write, .tx_octet,
    .tx_octet_valid, .interrupt_out_n);
  tcp_cell_writer u_tcp_cell_writer (.clk_sys, .rstn, .go, .bad, .fill, .busy, .tx_cell_bus, .tx_cell_start,
    .tx_cell_write);
  task automatic summarize();
    $display("tests_run=%0d miscompares=%0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : summarize
  task automatic to();
    miscompares++;
    $display("BAD %0t timeout", $time);
    summarize();
  endtask : to
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [8:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_sel_i <= 4'hf;
    wb_adr_i <= {idx, 2'b00};
    wb_dat_i <= {24'h000000, d};
    do begin
      @(posedge clk_sys);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20) to();
    q = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb
  task automatic send(input logic [7:0] f, input logic b);
    int n;
    n = 0;
    @(posedge clk_sys);
    fill <= f;
    bad <= b;
    go <= 1'b1;
    @(posedge clk_sys);
    go <= 1'b0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (busy !== 1'b0 && n < 80);
    if (n >= 80) to();
  endtask : send
  // Collects one whole cell, starting at its first octet
  task automatic cap();
    int n, k;
    n = 0;
    k = 0;
    while (k < 53 && n < 2000) begin
      @(posedge clk_sys);
      n++;
      if (tx_octet_valid === 1'b1 && (k > 0 || tx_octet.first === 1'b1)) begin
        if (k == 0) cid = tx_octet.idle;
        c[k] = tx_octet.data;
        k++;
      end
    end
    if (k < 53) to();
  endtask : cap
  function automatic logic [7:0] crc8(input logic [31:0] h);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 31; i >= 0; i--) r = {r[6:0], 1'b0} ^ ((r[7] ^ h[i]) ? CRC_POLY : 8'h00);
    return r;
  endfunction : crc8
  task automatic t_regs();
    wb(1'b0, IDX_CTRL, 8'h00);
    chk(q & CTRL_WR_MASK, RST_CTRL);
    wb(1'b0, IDX_IDLE_HDR, 8'h00);
    chk(q, RST_IDLE_HDR);
    wb(1'b0, IDX_IDLE_PAY, 8'h00);
    chk(q, RST_IDLE_PAY);
    wb(1'b0, 9'h000, 8'h00);
    chk(q, 8'h00);
    wb(1'b1, IDX_CTRL, 8'h62);
    wb(1'b0, IDX_CTRL, 8'h00);
    chk(q, 8'h02);
    $display("regs done");
  endtask : t_regs
  task automatic t_idle();
    logic [7:0] cv [3];
    cv = '{8'h02, 8'h06, 8'h12};
    wb(1'b1, IDX_IDLE_HDR, 8'ha5);
    for (int i = 0; i < 3; i++) begin
      wb(1'b1, IDX_CTRL, cv[i]);
      cap();
      chk({7'h00, cid}, 8'h01);
      chk(c[0], 8'ha0);
      chk(c[3], 8'h05);
      chk(c[4], crc8(32'ha0000005) ^ (cv[i][2] ? COSET : 8'h00) ^ {8{cv[i][4]}});
      chk(c[5], 8'h6a);
      chk(c[52], 8'h6a);
    end
    $display("idle done");
  endtask : t_idle
  task automatic t_scr();
    int n, e;
    n = 0;
    e = 0;
    wb(1'b1, IDX_CTRL, 8'h04);
    cap();
    for (int k = 5; k < 53; k++) n += int'(c[k] !== 8'h6a);
    chk({7'h00, n > 0}, 8'h01);
    // From payload bit 43 on, each bit is the plain bit XOR the line bit 43 earlier
    for (int j = 43; j < 384; j++) begin
      e += int'(c[5 + j / 8][7 - j % 8] !== (RST_IDLE_PAY[7 - j % 8] ^ c[5 + (j - 43) / 8][7 - (j - 43) % 8]));
    end
    chk({7'h00, e > 0}, 8'h00);
    $display("scramble done");
  endtask : t_scr
  task automatic t_fwd();
    wb(1'b1, IDX_CTRL, 8'h0a);
    send(8'h30, 1'b0);
    cid = 1'b1;
    for (int t = 0; t < 3 && cid !== 1'b0; t++) cap();
    chk({7'h00, cid}, 8'h00);
    chk(c[0], 8'h30);
    chk(c[4], 8'h34);
    chk(c[52], 8'h64);
    $display("forward done");
  endtask : t_fwd
  task automatic t_ovr();
    logic [7:0] last;
    last = 8'h00;
    wb(1'b1, IDX_CTRL, 8'h8a);
    for (int i = 0; i < 6; i++) send(8'h10 + 8'(i), 1'b0);
    repeat (3) @(posedge clk_sys);
    chk({7'h00, interrupt_out_n}, 8'h00);
    wb(1'b0, IDX_CTRL, 8'h00);
    chk(q & 8'h60, 8'h20);
    wb(1'b0, IDX_CTRL, 8'h00);
    chk(q & 8'h60, 8'h00);
    wb(1'b1, IDX_IRQ_EN, 8'h01);
    repeat (3) @(posedge clk_sys);
    chk({7'h00, interrupt_out_n}, 8'h00);
    wb(1'b1, IDX_IRQ_CLR, 8'h01);
    wb(1'b0, IDX_IRQ_STAT, 8'h00);
    chk(q, 8'h00);
    chk({7'h00, interrupt_out_n}, 8'h01);
    // Four stored cells drain in order; the two dropped ones never show
    cid = 1'b0;
    for (int t = 0; t < 6 && cid !== 1'b1; t++) begin
      cap();
      if (cid === 1'b0) last = c[0];
    end
    chk(last, 8'h13);
    chk({7'h00, cid}, 8'h01);
    $display("overrun done");
  endtask : t_ovr
  task automatic t_flush();
    // Two cells, both still stored when the flush lands
    send(8'h50, 1'b0);
    send(8'h51, 1'b0);
    wb(1'b1, IDX_CTRL, 8'h0b);
    cap();
    chk({7'h00, cid}, 8'h01);
    send(8'h20, 1'b0);
    wb(1'b1, IDX_CTRL, 8'h0a);
    cap();
    chk({7'h00, cid}, 8'h01);
    $display("flush done");
  endtask : t_flush
  task automatic t_misp();
    send(8'h40, 1'b1);
    chk({7'h00, interrupt_out_n}, 8'h01);
    wb(1'b0, IDX_IRQ_STAT, 8'h00);
    chk(q, 8'h02);
    wb(1'b0, IDX_CTRL, 8'h00);
    chk(q & 8'h60, 8'h40);
    $display("misplaced done");
  endtask : t_misp
  initial begin
    rstn = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_sel_i = 4'h0;
    wb_adr_i = '0;
    wb_dat_i = '0;
    go = 1'b0;
    bad = 1'b0;
    fill = 8'h00;
    repeat (5) @(posedge clk_sys);
    rstn <= 1'b1;
    t_regs();
    t_idle();
    t_scr();
    t_fwd();
    t_ovr();
    t_flush();
    t_misp();
    summarize();
  end
endmodule : tcp_tx_cell_processor_tb_top
`default_nettype wire
